//--- include/safety_interlock_pkg.sv
// constants for the output interlock: register map, fields, mode codes
// assumes a 32-bit axi4-lite register bus and byte addressing
`default_nettype none
package safety_interlock_pkg;
    // register byte offsets
    localparam logic [31:0] CFG_OFFSET = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
    // config register field positions
    localparam int CFG_BUS_EN_BIT = 0;
    localparam int CFG_PERMIT_BIT = 1;
    localparam int CFG_PIN17_BIT = 2;
    localparam int CFG_DIR_LSB = 4;
    localparam int CFG_STOP_LSB = 8;
    // bus enable: 0 follows permit, 1 always on
    localparam logic BUS_EN_PERMIT = 1'h0;
    localparam logic BUS_EN_ALWAYS = 1'h1;
    // permit source: 0 ignores pump, 1 needs pump healthy
    localparam logic PERMIT_NO_PUMP = 1'h0;
    localparam logic PERMIT_WITH_PUMP = 1'h1;
    // pin 17 source: 0 pass select-in, 1 show permit
    localparam logic PIN17_NORMAL = 1'h0;
    localparam logic PIN17_PERMIT = 1'h1;
    // data bus direction codes
    localparam logic [1:0] DIR_OUT = 2'h0;
    localparam logic [1:0] DIR_DYNAMIC = 2'h1;
    localparam logic [1:0] DIR_IN = 2'h2;
    // stop mode codes
    localparam logic [1:0] STOP_NORMAL = 2'h0;
    localparam logic [1:0] STOP_DAISY = 2'h1;
    localparam logic [1:0] STOP_OPEN = 2'h2;
    // config reset value: direction out, normal stop, no pump
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK = 32'h0000_0337;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

//--- include/interlock_cfg_if.sv
// config and status carried between register slave and interlock core
// assumes both sides run on the same system clock
`timescale 1ns/10ps
`default_nettype none
interface interlock_cfg_if;
    logic bus_enable_select;
    logic permit_source_select;
    logic pin17_source_select;
    logic [1:0] bus_direction_select;
    logic [1:0] stop_mode_select;
    logic [7:0] status;
    // register side drives config, reads status
    modport regs (
        output bus_enable_select, permit_source_select,
        output pin17_source_select, bus_direction_select,
        output stop_mode_select,
        input status
    );
    // core side reads config, drives status
    modport core (
        input bus_enable_select, permit_source_select,
        input pin17_source_select, bus_direction_select,
        input stop_mode_select,
        output status
    );
endinterface
`default_nettype wire

//--- logic/interlock_regs.sv
// axi4-lite slave holding the selection register and a status view
// assumes one write and one read at most under way at a time
`timescale 1ns/10ps
`default_nettype none
module interlock_regs (
    input wire logic clk,
    input wire logic rst,
    // write channels
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read channels
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // towards the core
    interlock_cfg_if.regs cfg
);
    logic aw_held_reg, w_held_reg;
    logic [31:0] awaddr_reg, wdata_reg, cfg_reg, wmask;
    logic [3:0] wstrb_reg;
    logic do_write;

    // each channel is taken once and held until the response goes
    assign awready = !aw_held_reg && !bvalid;
    assign wready = !w_held_reg && !bvalid;
    assign do_write = aw_held_reg && w_held_reg && !bvalid;
    assign arready = !rvalid;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // byte strobes widen to a bit mask, limited to defined fields
    assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
        {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}}
        & safety_interlock_pkg::CFG_WMASK;

    // config store and write response
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_reg <= safety_interlock_pkg::CFG_RESET;
            bvalid <= 1'b0;
            bresp <= safety_interlock_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            if (awaddr_reg[31:2] == safety_interlock_pkg::CFG_OFFSET[31:2])
            begin
                cfg_reg <= (cfg_reg & ~wmask) | (wdata_reg & wmask);
                bresp <= safety_interlock_pkg::RESP_OKAY;
            end else if (awaddr_reg[31:2]
                == safety_interlock_pkg::STATUS_OFFSET[31:2]) begin
                bresp <= safety_interlock_pkg::RESP_OKAY;
            end else begin
                bresp <= safety_interlock_pkg::RESP_DECERR;
            end
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= safety_interlock_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= safety_interlock_pkg::RESP_OKAY;
            if (araddr[31:2] == safety_interlock_pkg::CFG_OFFSET[31:2]) begin
                rdata <= cfg_reg;
            end else if (araddr[31:2]
                == safety_interlock_pkg::STATUS_OFFSET[31:2]) begin
                rdata <= {24'h00_0000, cfg.status};
            end else begin
                rdata <= 32'h0000_0000;
                rresp <= safety_interlock_pkg::RESP_DECERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // fields out to the core
    assign cfg.bus_enable_select =
        cfg_reg[safety_interlock_pkg::CFG_BUS_EN_BIT];
    assign cfg.permit_source_select =
        cfg_reg[safety_interlock_pkg::CFG_PERMIT_BIT];
    assign cfg.pin17_source_select =
        cfg_reg[safety_interlock_pkg::CFG_PIN17_BIT];
    assign cfg.bus_direction_select =
        cfg_reg[safety_interlock_pkg::CFG_DIR_LSB +: 2];
    assign cfg.stop_mode_select =
        cfg_reg[safety_interlock_pkg::CFG_STOP_LSB +: 2];
endmodule // interlock_regs
`default_nettype wire

//--- logic/safety_output_interlock.sv
// interlock and routing between a pc parallel port and machine terminals
// assumes pins are asynchronous and settings change only while idle
`timescale 1ns/10ps
`default_nettype none
module safety_output_interlock (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // axi4-lite write
    input wire logic [31:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read
    input wire logic [31:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // machine-side safety inputs
    input wire logic ESTOP,
    input wire logic FAULT_N,
    input wire logic FAULT_DRIVEN,
    input wire logic PUMP_HEALTHY,
    // pc control lines
    input wire logic SELECT_IN_N,
    input wire logic AUTO_FEED_N,
    input wire logic INIT_N,
    input wire logic STROBE_N,
    // pc data bus, two-way
    input wire logic [7:0] PC_DATA_IN,
    output logic [7:0] PC_DATA_OUT,
    output logic [7:0] PC_DATA_OE,
    // machine data bus, two-way
    input wire logic [7:0] MACH_DATA_IN,
    output logic [7:0] MACH_DATA_OUT,
    output logic [7:0] MACH_DATA_OE,
    // status inputs and their copy to the pc
    input wire logic [3:0] STATUS_IN,
    output logic [3:0] STATUS_TO_PC,
    output logic ACK_TO_PC,
    // control outputs: 0 auto feed, 1 init, 2 pin 17
    output logic [2:0] CTRL_OUT,
    output logic [2:0] CTRL_OE,
    output logic PUMP_DRIVE,
    output logic RELAY_DRIVE,
    // indicators
    output logic [7:0] DATA_LED,
    output logic [3:0] STATUS_LED,
    output logic [2:0] CTRL_LED,
    output logic OUTPUTS_ENABLED_LED,
    output logic RELAY_LED,
    output logic STOP_ACTIVE_LED
);
    ////////////////////////////////////////////////////////////////////
    // input synchronisers
    localparam int NUM_PINS = 28;
    logic [NUM_PINS-1:0] pin_raw, sync1_reg, sync2_reg;
    logic s_estop, s_fault_n, s_fault_driven, s_pump;
    logic s_selin, s_autofeed, s_init, s_strobe;
    logic [3:0] s_status;
    logic [7:0] s_pc_data, s_mach_data;

    assign pin_raw = {ESTOP, FAULT_N, FAULT_DRIVEN, PUMP_HEALTHY,
        SELECT_IN_N, AUTO_FEED_N, INIT_N, STROBE_N, STATUS_IN,
        PC_DATA_IN, MACH_DATA_IN};

    // two flops per pin; the first is seen only by the second
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_sync
            always_ff @(posedge SYS_CLK or posedge RST) begin
                if (RST) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    assign {s_estop, s_fault_n, s_fault_driven, s_pump, s_selin,
        s_autofeed, s_init, s_strobe, s_status, s_pc_data,
        s_mach_data} = sync2_reg;

    ////////////////////////////////////////////////////////////////////
    // register slave
    interlock_cfg_if cfg_bus ();

    interlock_regs u_regs (
        .clk(SYS_CLK),
        .rst(RST),
        .awaddr(AWADDR),
        .awvalid(AWVALID),
        .awready(AWREADY),
        .wdata(WDATA),
        .wstrb(WSTRB),
        .wvalid(WVALID),
        .wready(WREADY),
        .bresp(BRESP),
        .bvalid(BVALID),
        .bready(BREADY),
        .araddr(ARADDR),
        .arvalid(ARVALID),
        .arready(ARREADY),
        .rdata(RDATA),
        .rresp(RRESP),
        .rvalid(RVALID),
        .rready(RREADY),
        .cfg(cfg_bus.regs)
    );

    ////////////////////////////////////////////////////////////////////
    // permit and routing, all combinational
    logic stop_normal, stop_daisy, fault_level, fault_active;
    logic stop_blocks, permit, bus_en, dir_out, pin17_permit;
    logic ack_next, pin17_val, pin17_oe;
    logic [7:0] line_level;

    assign stop_normal = cfg_bus.stop_mode_select
        == safety_interlock_pkg::STOP_NORMAL;
    assign stop_daisy = cfg_bus.stop_mode_select
        == safety_interlock_pkg::STOP_DAISY;

    // undriven fault pin resolves per stop mode
    // daisy pulls low (fault), others pull high (no fault)
    assign fault_level = s_fault_driven ? s_fault_n : !stop_daisy;
    assign fault_active = !fault_level;

    // estop only blocks outputs in normal mode
    assign stop_blocks = stop_normal && s_estop;

    // permit from fault, stop and pump
    assign permit = !fault_active && !stop_blocks
        && (cfg_bus.permit_source_select
            == safety_interlock_pkg::PERMIT_NO_PUMP || s_pump);

    assign bus_en = (cfg_bus.bus_enable_select
        == safety_interlock_pkg::BUS_EN_ALWAYS) || permit;

    // direction; high select-in means towards machine
    always_comb begin
        unique case (cfg_bus.bus_direction_select)
            safety_interlock_pkg::DIR_OUT: dir_out = 1'b1;
            safety_interlock_pkg::DIR_DYNAMIC: dir_out = s_selin;
            safety_interlock_pkg::DIR_IN: dir_out = 1'b0;
            default: dir_out = 1'b1; // unused code, safest is output
        endcase
    end

    // ack high on stop, and on fault in normal mode
    assign ack_next = s_estop || (stop_normal && fault_active);

    assign pin17_permit = cfg_bus.pin17_source_select
        == safety_interlock_pkg::PIN17_PERMIT;
    assign pin17_val = pin17_permit ? permit : s_selin;
    // permit mode keeps driving so the pin falls low on loss of permit
    assign pin17_oe = pin17_permit || permit;

    // level seen on the machine-side data terminals
    assign line_level = dir_out ? s_pc_data : s_mach_data;

    ////////////////////////////////////////////////////////////////////
    // data bus drivers
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            PC_DATA_OUT <= 8'h00;
            PC_DATA_OE <= 8'h00;
            MACH_DATA_OUT <= 8'h00;
            MACH_DATA_OE <= 8'h00;
        end else begin
            // one side drives while the bus is enabled, the other listens
            MACH_DATA_OUT <= s_pc_data;
            PC_DATA_OUT <= s_mach_data;
            MACH_DATA_OE <= {8{bus_en && dir_out}};
            PC_DATA_OE <= {8{bus_en && !dir_out}};
        end
    end

    // control outputs, pump feed, relay and ack
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            CTRL_OUT <= 3'h0;
            CTRL_OE <= 3'h0;
            PUMP_DRIVE <= 1'b0;
            RELAY_DRIVE <= 1'b0;
            ACK_TO_PC <= 1'b0;
            STATUS_TO_PC <= 4'h0;
        end else begin
            CTRL_OUT <= {pin17_val, s_init, s_autofeed};
            CTRL_OE <= {pin17_oe, permit, permit};
            PUMP_DRIVE <= s_selin;
            RELAY_DRIVE <= s_strobe;
            ACK_TO_PC <= ack_next;
            STATUS_TO_PC <= s_status;
        end
    end

    // indicators; an undriven control terminal floats low
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            DATA_LED <= 8'h00;
            STATUS_LED <= 4'h0;
            CTRL_LED <= 3'h0;
            OUTPUTS_ENABLED_LED <= 1'b0;
            RELAY_LED <= 1'b0;
            STOP_ACTIVE_LED <= 1'b0;
        end else begin
            DATA_LED <= ~line_level;
            STATUS_LED <= ~s_status;
            CTRL_LED <= {pin17_oe && pin17_val, permit && s_init,
                permit && s_autofeed};
            OUTPUTS_ENABLED_LED <= permit;
            RELAY_LED <= s_strobe;
            STOP_ACTIVE_LED <= s_estop || (stop_normal && fault_active);
        end
    end

    // status word for software
    assign cfg_bus.status = {1'b0, ACK_TO_PC, dir_out, bus_en, s_pump,
        fault_active, s_estop, permit};

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_bus_always;
        @(posedge SYS_CLK) disable iff (RST)
        (cfg_bus.bus_enable_select && dir_out) |=> (MACH_DATA_OE == 8'hFF);
    endproperty
    a_bus_always: assert property (p_bus_always)
        else $error("data buffers off in always mode");

    property p_bus_permit;
        @(posedge SYS_CLK) disable iff (RST)
        (!cfg_bus.bus_enable_select && !permit)
            |=> (MACH_DATA_OE == 8'h00) && (PC_DATA_OE == 8'h00);
    endproperty
    a_bus_permit: assert property (p_bus_permit)
        else $error("data buffers on without permit");

    property p_permit_no_pump;
        @(posedge SYS_CLK) disable iff (RST)
        (!cfg_bus.permit_source_select && s_fault_driven && s_fault_n
            && !stop_blocks) |=> OUTPUTS_ENABLED_LED && CTRL_OE[0];
    endproperty
    a_permit_no_pump: assert property (p_permit_no_pump)
        else $error("permit withheld without fault");

    property p_permit_pump;
        @(posedge SYS_CLK) disable iff (RST)
        (cfg_bus.permit_source_select && !s_pump) |=> !OUTPUTS_ENABLED_LED;
    endproperty
    a_permit_pump: assert property (p_permit_pump)
        else $error("permit given with pump unhealthy");

    property p_pin17_normal;
        @(posedge SYS_CLK) disable iff (RST)
        !pin17_permit |=> CTRL_OUT[2] == $past(s_selin)
            && PUMP_DRIVE == CTRL_OUT[2];
    endproperty
    a_pin17_normal: assert property (p_pin17_normal)
        else $error("pin 17 not following select-in");

    property p_pin17_permit;
        @(posedge SYS_CLK) disable iff (RST)
        pin17_permit |=> CTRL_OE[2] && CTRL_OUT[2] == OUTPUTS_ENABLED_LED;
    endproperty
    a_pin17_permit: assert property (p_pin17_permit)
        else $error("pin 17 not showing permit");

    property p_dir_dynamic;
        @(posedge SYS_CLK) disable iff (RST)
        (cfg_bus.bus_direction_select == safety_interlock_pkg::DIR_DYNAMIC
            && bus_en) |=> MACH_DATA_OE[0] == $past(s_selin);
    endproperty
    a_dir_dynamic: assert property (p_dir_dynamic)
        else $error("direction not following select-in");

    property p_dir_in;
        @(posedge SYS_CLK) disable iff (RST)
        (cfg_bus.bus_direction_select == safety_interlock_pkg::DIR_IN)
            |=> MACH_DATA_OE == 8'h00 && PC_DATA_OUT == $past(s_mach_data);
    endproperty
    a_dir_in: assert property (p_dir_in)
        else $error("input direction drives machine side");

    property p_ack_gp;
        @(posedge SYS_CLK) disable iff (RST)
        !stop_normal ##1 !$past(stop_normal) |-> ACK_TO_PC == $past(s_estop);
    endproperty
    a_ack_gp: assert property (p_ack_gp)
        else $error("ack not a copy of estop");

    property p_ack_normal;
        @(posedge SYS_CLK) disable iff (RST)
        stop_normal |=> ACK_TO_PC == ($past(s_estop) || $past(fault_active));
    endproperty
    a_ack_normal: assert property (p_ack_normal)
        else $error("ack not stop or fault in normal mode");

    property p_daisy_float;
        @(posedge SYS_CLK) disable iff (RST)
        (stop_daisy && !s_fault_driven) |=> !OUTPUTS_ENABLED_LED
            && CTRL_OE[1:0] == 2'h0;
    endproperty
    a_daisy_float: assert property (p_daisy_float)
        else $error("floating fault not active in daisy mode");
endmodule // safety_output_interlock
`default_nettype wire

//--- tb/pc_mach_partner.sv
// far side model: pc data pins and machine data terminals
// assumes the bench sets the level each far side would drive
`timescale 1ns/10ps
`default_nettype none
module pc_mach_partner (
    // far-side levels
    input wire logic [7:0] pc_val,
    input wire logic [7:0] mach_val,
    // design pins
    input wire logic [7:0] pc_out,
    input wire logic [7:0] pc_oe,
    input wire logic [7:0] mach_out,
    input wire logic [7:0] mach_oe,
    // resolved wire levels
    output logic [7:0] pc_wire,
    output logic [7:0] mach_wire
);
    // driven lanes win
    // far side backs off a driven lane, so no contention is modelled
    assign pc_wire = (pc_oe & pc_out) | (~pc_oe & pc_val);
    assign mach_wire = (mach_oe & mach_out) | (~mach_oe & mach_val);
endmodule // pc_mach_partner
`default_nettype wire

//--- tb/safety_output_interlock_tb.sv
// bench for the output interlock: register bus, mode table, data paths
// assumes the partner model resolves both data buses
`timescale 1ns/10ps
`default_nettype none
module safety_output_interlock_tb;
    typedef struct packed {
        logic [9:0] cfg;
        logic [4:0] pin; // estop fault_n driven pump select_in_n
        logic [6:0] exp; // ack led stop mach_oe pc_oe pin17_led pump
    } row_t;
    logic SYS_CLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic ARVALID, ARREADY, RVALID, RREADY, ESTOP, FAULT_N, FAULT_DRIVEN;
    logic PUMP_HEALTHY, SELECT_IN_N, AUTO_FEED_N, INIT_N, STROBE_N;
    logic ACK_TO_PC, PUMP_DRIVE, RELAY_DRIVE, OUTPUTS_ENABLED_LED;
    logic RELAY_LED, STOP_ACTIVE_LED;
    logic [31:0] AWADDR, WDATA, ARADDR, RDATA, rd;
    logic [3:0] WSTRB, STATUS_IN, STATUS_TO_PC, STATUS_LED;
    logic [1:0] BRESP, RRESP, rs;
    logic [7:0] PC_DATA_IN, PC_DATA_OUT, PC_DATA_OE, MACH_DATA_IN;
    logic [7:0] MACH_DATA_OUT, MACH_DATA_OE, DATA_LED, pc_val, mach_val;
    logic [2:0] CTRL_OUT, CTRL_OE, CTRL_LED;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    // one row per mode corner; expectations worked from the mode rules
    row_t rows[17] = '{
        {10'h000, 5'b01101, 7'b0101011}, {10'h000, 5'b11101, 7'b1010001},
        {10'h000, 5'b00101, 7'b1010001}, {10'h000, 5'b00001, 7'b0101011},
        {10'h001, 5'b11101, 7'b1011001}, {10'h002, 5'b01101, 7'b0000001},
        {10'h002, 5'b01111, 7'b0101011}, {10'h004, 5'b01100, 7'b0101010},
        {10'h004, 5'b11100, 7'b1010000}, {10'h010, 5'b01101, 7'b0101011},
        {10'h010, 5'b01100, 7'b0100100}, {10'h020, 5'b01101, 7'b0100111},
        {10'h100, 5'b00001, 7'b0000001}, {10'h100, 5'b11101, 7'b1111011},
        {10'h200, 5'b10001, 7'b1111011}, {10'h030, 5'b01100, 7'b0101000},
        {10'h300, 5'b10001, 7'b1111011}};

    safety_output_interlock u_dut (
        .SYS_CLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
        .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
        .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .ESTOP, .FAULT_N,
        .FAULT_DRIVEN, .PUMP_HEALTHY, .SELECT_IN_N, .AUTO_FEED_N, .INIT_N,
        .STROBE_N, .PC_DATA_IN, .PC_DATA_OUT, .PC_DATA_OE, .MACH_DATA_IN,
        .MACH_DATA_OUT, .MACH_DATA_OE, .STATUS_IN, .STATUS_TO_PC,
        .ACK_TO_PC, .CTRL_OUT, .CTRL_OE, .PUMP_DRIVE, .RELAY_DRIVE,
        .DATA_LED, .STATUS_LED, .CTRL_LED, .OUTPUTS_ENABLED_LED,
        .RELAY_LED, .STOP_ACTIVE_LED);

    pc_mach_partner u_far (
        .pc_val(pc_val), .mach_val(mach_val), .pc_out(PC_DATA_OUT),
        .pc_oe(PC_DATA_OE), .mach_out(MACH_DATA_OUT),
        .mach_oe(MACH_DATA_OE), .pc_wire(PC_DATA_IN),
        .mach_wire(MACH_DATA_IN));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end
    // ceiling well above the few hundred cycles the run needs
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        logic pa, pw;
        // one edge spare so bready is never lowered and raised at once
        @(posedge SYS_CLK);
        pa = 1'b1;
        pw = 1'b1;
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= 4'hF;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (pa || pw) begin
            @(posedge SYS_CLK);
            if (pa && AWREADY === 1'b1) begin
                pa = 1'b0;
                AWVALID <= 1'b0;
            end
            if (pw && WREADY === 1'b1) begin
                pw = 1'b0;
                WVALID <= 1'b0;
            end
        end
        do @(posedge SYS_CLK); while (BVALID !== 1'b1);
        rs = BRESP;
        BREADY <= 1'b0;
    endtask
    task automatic axr(input logic [31:0] a);
        @(posedge SYS_CLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge SYS_CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge SYS_CLK); while (RVALID !== 1'b1);
        rd = RDATA;
        rs = RRESP;
        RREADY <= 1'b0;
    endtask
    // two sync flops plus output flop, one edge spare
    task automatic settle();
        repeat (4) @(posedge SYS_CLK);
    endtask
    task automatic test_done();
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        RST = 1'b1;
        {AWADDR, WDATA, WSTRB, ARADDR, AWVALID, WVALID, BREADY} = '0;
        {ARVALID, RREADY, ESTOP, FAULT_DRIVEN, PUMP_HEALTHY, INIT_N} = '0;
        {FAULT_N, SELECT_IN_N, AUTO_FEED_N, STROBE_N} = '1;
        pc_val = 8'hA5;
        mach_val = 8'h3C;
        STATUS_IN = 4'h6;
        repeat (5) @(posedge SYS_CLK);
        chk(OUTPUTS_ENABLED_LED, 1'b0);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        // register map: reset value, write mask, unmapped and read-only
        axr(safety_interlock_pkg::CFG_OFFSET);
        chk(rd, safety_interlock_pkg::CFG_RESET);
        axw(safety_interlock_pkg::CFG_OFFSET, 32'hFFFF_FFFF);
        chk(rs, safety_interlock_pkg::RESP_OKAY);
        axr(safety_interlock_pkg::CFG_OFFSET);
        chk(rd, safety_interlock_pkg::CFG_WMASK);
        axw(32'h0000_0040, 32'h0000_0000);
        chk(rs, safety_interlock_pkg::RESP_DECERR);
        axr(32'h0000_0040);
        chk(rd, 32'h0000_0000);
        chk(rs, safety_interlock_pkg::RESP_DECERR);
        axw(safety_interlock_pkg::STATUS_OFFSET, 32'hFFFF_FFFF);
        chk(rs, safety_interlock_pkg::RESP_OKAY);
        // mode table
        foreach (rows[i]) begin
            axw(safety_interlock_pkg::CFG_OFFSET, {22'h0, rows[i].cfg});
            {ESTOP, FAULT_N, FAULT_DRIVEN, PUMP_HEALTHY, SELECT_IN_N} <=
                rows[i].pin;
            settle();
            chk(ACK_TO_PC, rows[i].exp[6]);
            chk(OUTPUTS_ENABLED_LED, rows[i].exp[5]);
            chk(STOP_ACTIVE_LED, rows[i].exp[4]);
            chk(MACH_DATA_OE, {8{rows[i].exp[3]}});
            chk(PC_DATA_OE, {8{rows[i].exp[2]}});
            chk(CTRL_LED, {rows[i].exp[1], 1'b0, rows[i].exp[5]});
            chk(PUMP_DRIVE, rows[i].exp[0]);
        end
        // data paths, relay and status copies
        axw(safety_interlock_pkg::CFG_OFFSET, 32'h0000_0000);
        {ESTOP, FAULT_N, FAULT_DRIVEN, PUMP_HEALTHY, SELECT_IN_N} <= 5'h0D;
        {INIT_N, AUTO_FEED_N} <= 2'b10;
        settle();
        chk(MACH_DATA_OUT, 8'hA5);
        chk(DATA_LED, 8'h5A);
        chk({RELAY_DRIVE, RELAY_LED}, 2'h3);
        chk({STATUS_TO_PC, STATUS_LED}, 8'h69);
        chk({CTRL_OUT, CTRL_OE, CTRL_LED}, 9'h1BE);
        axr(safety_interlock_pkg::STATUS_OFFSET);
        chk(rd, 32'h0000_0031);
        axw(safety_interlock_pkg::CFG_OFFSET, 32'h0000_0020);
        STROBE_N <= 1'b0;
        settle();
        chk(PC_DATA_OUT, 8'h3C);
        chk(DATA_LED, 8'hC3);
        chk({RELAY_DRIVE, RELAY_LED}, 2'h0);
        // reset in mid-run clears outputs and settings
        RST <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        chk({OUTPUTS_ENABLED_LED, PC_DATA_OE}, 9'h000);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        axr(safety_interlock_pkg::CFG_OFFSET);
        chk(rd, safety_interlock_pkg::CFG_RESET);
        test_done();
    end
endmodule // safety_output_interlock_tb
`default_nettype wire
